// File: design/epc_pkg.sv
// Purpose: Constants for the power, temperature and boost configuration register bank
// Assumes: Commands arrive as already-deserialized bytes on core_clk
// Notes: Command codes double as register offsets
//
// What this block does
// [RL1] Source saving width code times half microsecond; code zero reserved; default five.
// [RL2] Host keeps common-electrode saving width below common data interval setting.
// [RL3] Host keeps source saving width below source-to-gate gap setting.
// [RL4] Command E4 takes one byte; only two low bits meaningful.
// [RL5] Threshold 00=2.2V 01=2.3V 10=2.4V 11=2.5V; 11 after reset.
// [RL6] Command E6 byte, reset zero, is used only when fixed-temperature bit set.
// [RL7] Temperature byte is two's complement, one degree per step, -25 to 50 valid.
// [RL8] Command E7 takes two bytes; first low six bits drive strength, default 010000b.
// [RL9] Second byte low six bits minimum off time, default 000101b, only in boost mode.
// [RL10] Temperature source bit: zero internal sensor, one manual value; reset zero.
// [RL11] Power-saving intervals applied whenever common or source output flips polarity.
// [RL12] Host sends no reserved codes and sends each command with all its parameters; the bench sends source code zero and cuts one E7 short.
package epc_pkg;
	localparam logic [7:0] CMD_TEMP_INPUT_CFG = 8'he0;
	localparam logic [7:0] CMD_POWER_SAVING = 8'he3;
	localparam logic [7:0] CMD_LOW_VOLTAGE = 8'he4;
	localparam logic [7:0] CMD_MANUAL_TEMP = 8'he6;
	localparam logic [7:0] CMD_BOOST_SOFT_START = 8'he7;
	localparam int TEMP_SRC_BIT = 1;
	localparam logic [7:0] RST_POWER_SAVING = 8'h65;
	localparam logic [1:0] RST_LOW_VOLTAGE = 2'h3;
	localparam logic [7:0] RST_MANUAL_TEMP = 8'h00;
	localparam logic [5:0] RST_BOOST_DRIVE = 6'h10;
	localparam logic [5:0] RST_BOOST_OFF = 6'h05;
	localparam logic [7:0] TEMP_MIN = 8'he7;
	localparam logic [7:0] TEMP_MAX = 8'h32;
	// Half microsecond step in ns, and cycles per step at 25 ns period
	localparam int SAVE_STEP_NS = 500;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SAVE_STEP_CYC = SAVE_STEP_NS / CLK_PERIOD_NS;
	// Millivolt thresholds for the four low-supply codes
	localparam logic [11:0] LVD_MV_BASE = 12'h898;
	localparam logic [11:0] LVD_MV_STEP = 12'h064;
endpackage

// File: design/epc_save_timer.sv
// Purpose: Power-saving pulse timer started on each output polarity flip
// Assumes: Width code is nonzero; flip strobe is one cycle on core_clk
// Notes: Pulse lasts code times step cycles
`timescale 1ns/1ps
module epc_save_timer (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic flip,
	input wire logic [3:0] width_code,
	output logic active
);
	typedef struct packed {
		logic [9:0] cnt;
		logic act;
	} epc_tmr_s;
	epc_tmr_s st;
	epc_tmr_s next_st;
	// Load on a flip, count down otherwise
	always_comb begin
		next_st = st;
		if (flip && width_code != 4'h0) begin
			next_st.cnt = 10'(width_code * epc_pkg::SAVE_STEP_CYC); // RL1
			next_st.act = 1'b1; // RL11
		end else if (st.cnt > 10'h001) begin
			next_st.cnt = st.cnt - 10'h001;
		end else begin
			next_st.cnt = 10'h000;
			next_st.act = 1'b0;
		end
	end
	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign active = st.act;
	property p_width;
		@(posedge core_clk) disable iff (rst)
		(flip && width_code == 4'h1) |=> active [*8] ##13 !active;
	endproperty
	a_width: assert property (p_width) else $error("Saving width wrong for code one"); // RL1
endmodule

// File: design/epc_regs.sv
// Purpose: Command register bank for power saving, low supply, temperature and boost
// Assumes: Host delivers decoded bytes with a data/command flag on core_clk
// Notes: Registers are write-only from the host; values go to the sequencer
`timescale 1ns/1ps
module epc_regs (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic byte_valid,
	input wire logic byte_is_data,
	input wire logic [7:0] byte_data,
	input wire logic [7:0] sensor_temp,
	input wire logic boost_switch_mode,
	input wire logic com_flip,
	input wire logic src_flip,
	output logic [3:0] source_saving_width,
	output logic [3:0] com_saving_width,
	output logic [1:0] low_voltage_threshold,
	output logic [11:0] lvd_threshold_mv,
	output logic temp_source_select,
	output logic [7:0] manual_temp_value,
	output logic [7:0] active_temp,
	output logic temp_reserved,
	output logic [5:0] gate_boost_drive_strength,
	output logic [5:0] gate_boost_min_off_time,
	output logic [5:0] gate_boost_off_applied,
	output logic com_saving_active,
	output logic src_saving_active
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [2:0] {
		EPC_IDLE = 3'b001,
		EPC_ARG0 = 3'b010,
		EPC_ARG1 = 3'b100
	} epc_phase_e;
	typedef struct packed {
		epc_phase_e phase;
		logic [7:0] cmd;
		logic [7:0] power_saving_widths;
		logic [1:0] lvd;
		logic tfix;
		logic [7:0] tman;
		logic [5:0] drv;
		logic [5:0] offt;
		logic [7:0] temp;
		logic trsv;
		logic [11:0] mv;
		logic [5:0] offa;
		logic csav;
		logic ssav;
	} epc_regs_s;
	epc_regs_s st;
	epc_regs_s next_st;
	logic com_act;
	logic src_act;
	logic [7:0] sel_temp;
	// ****************************************
	// Saving timers
	// ****************************************
	// Common electrode saving uses the same half microsecond step
	epc_save_timer u_com (
		.core_clk(core_clk),
		.rst(rst),
		.flip(com_flip),
		.width_code(st.power_saving_widths[7:4]),
		.active(com_act)
	);
	// Source output saving pulse
	epc_save_timer u_src (
		.core_clk(core_clk),
		.rst(rst),
		.flip(src_flip),
		.width_code(st.power_saving_widths[3:0]),
		.active(src_act)
	);
	// ****************************************
	// Command decode and parameter capture
	// ****************************************
	// Command bytes open a sequence; data bytes fill the parameters
	always_comb begin
		next_st = st;
		sel_temp = st.tfix ? st.tman : sensor_temp; // RL10
		next_st.temp = sel_temp; // RL6
		next_st.trsv = st.tfix && ($signed(st.tman) < $signed(epc_pkg::TEMP_MIN) ||
			$signed(st.tman) > $signed(epc_pkg::TEMP_MAX)); // RL7
		next_st.mv = 12'(epc_pkg::LVD_MV_BASE + 12'(st.lvd) * epc_pkg::LVD_MV_STEP); // RL5
		next_st.offa = boost_switch_mode ? st.offt : 6'h00; // RL9
		next_st.csav = com_act; // RL11
		next_st.ssav = src_act; // RL11
		if (byte_valid) begin
			if (!byte_is_data) begin
				next_st.cmd = byte_data;
				next_st.phase = EPC_ARG0;
			end else begin
				case (st.phase)
					EPC_ARG0: begin
						next_st.phase = EPC_IDLE;
						case (st.cmd)
							epc_pkg::CMD_TEMP_INPUT_CFG: begin
								next_st.tfix = byte_data[epc_pkg::TEMP_SRC_BIT]; // RL10
							end
							epc_pkg::CMD_POWER_SAVING: begin
								next_st.power_saving_widths = byte_data; // RL1
							end
							epc_pkg::CMD_LOW_VOLTAGE: begin
								next_st.lvd = byte_data[1:0]; // RL4
							end
							epc_pkg::CMD_MANUAL_TEMP: begin
								next_st.tman = byte_data; // RL6
							end
							epc_pkg::CMD_BOOST_SOFT_START: begin
								next_st.drv = byte_data[5:0]; // RL8
								next_st.phase = EPC_ARG1;
							end
							default: begin
								next_st.phase = EPC_IDLE;
							end
						endcase
					end
					EPC_ARG1: begin
						next_st.offt = byte_data[5:0]; // RL9
						next_st.phase = EPC_IDLE;
					end
					EPC_IDLE: begin
						next_st.phase = EPC_IDLE; // Surplus data ignored
					end
					default: begin
						next_st.phase = EPC_IDLE;
					end
				endcase
			end
		end
	end
	// State register with documented reset values
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st.phase <= EPC_IDLE;
			st.cmd <= 8'h00;
			st.power_saving_widths <= epc_pkg::RST_POWER_SAVING;
			st.lvd <= epc_pkg::RST_LOW_VOLTAGE; // RL5
			st.tfix <= 1'b0;
			st.tman <= epc_pkg::RST_MANUAL_TEMP;
			st.drv <= epc_pkg::RST_BOOST_DRIVE;
			st.offt <= epc_pkg::RST_BOOST_OFF;
			st.temp <= 8'h00;
			st.trsv <= 1'b0;
			st.mv <= 12'(epc_pkg::LVD_MV_BASE + 12'(epc_pkg::RST_LOW_VOLTAGE) * epc_pkg::LVD_MV_STEP);
			st.offa <= 6'h00;
			st.csav <= 1'b0;
			st.ssav <= 1'b0;
		end else begin
			st <= next_st;
		end
	end
	// ****************************************
	// Outputs
	// ****************************************
	// All outputs straight from the state register
	assign source_saving_width = st.power_saving_widths[3:0];
	assign com_saving_width = st.power_saving_widths[7:4];
	assign low_voltage_threshold = st.lvd;
	assign lvd_threshold_mv = st.mv;
	assign temp_source_select = st.tfix;
	assign manual_temp_value = st.tman;
	assign active_temp = st.temp;
	assign temp_reserved = st.trsv;
	assign gate_boost_drive_strength = st.drv;
	assign gate_boost_min_off_time = st.offt;
	assign gate_boost_off_applied = st.offa;
	assign com_saving_active = st.csav;
	assign src_saving_active = st.ssav;
	// ****************************************
	// Checks
	// ****************************************
	property p_lvd_write;
		@(posedge core_clk) disable iff (rst)
		(byte_valid && byte_is_data && st.phase == EPC_ARG0 && st.cmd == epc_pkg::CMD_LOW_VOLTAGE)
		|=> low_voltage_threshold == $past(byte_data[1:0]);
	endproperty
	a_lvd_write: assert property (p_lvd_write) else $error("Threshold not stored"); // RL4
	property p_lvd_mv;
		@(posedge core_clk) disable iff (rst)
		##1 lvd_threshold_mv == 12'(12'h898 + 12'($past(st.lvd)) * 12'h064);
	endproperty
	a_lvd_mv: assert property (p_lvd_mv) else $error("Threshold millivolts wrong"); // RL5
	property p_temp_sel;
		@(posedge core_clk) disable iff (rst)
		1'b1 |=> active_temp == ($past(st.tfix) ? $past(st.tman) : $past(sensor_temp));
	endproperty
	a_temp_sel: assert property (p_temp_sel) else $error("Temperature source wrong"); // RL10
	property p_temp_rsv;
		@(posedge core_clk) disable iff (rst)
		(st.tfix && st.tman == 8'h33) |=> temp_reserved;
	endproperty
	a_temp_rsv: assert property (p_temp_rsv) else $error("Reserved temperature not flagged"); // RL7
	property p_tman;
		@(posedge core_clk) disable iff (rst)
		(byte_valid && byte_is_data && st.phase == EPC_ARG0 && st.cmd == epc_pkg::CMD_MANUAL_TEMP)
		|=> manual_temp_value == $past(byte_data);
	endproperty
	a_tman: assert property (p_tman) else $error("Manual temperature not stored"); // RL6
	property p_drv;
		@(posedge core_clk) disable iff (rst)
		(byte_valid && byte_is_data && st.phase == EPC_ARG0 &&
			st.cmd == epc_pkg::CMD_BOOST_SOFT_START)
		|=> gate_boost_drive_strength == $past(byte_data[5:0]) && st.phase == EPC_ARG1;
	endproperty
	a_drv: assert property (p_drv) else $error("Drive strength not stored"); // RL8
	property p_off;
		@(posedge core_clk) disable iff (rst)
		!boost_switch_mode |=> gate_boost_off_applied == 6'h00;
	endproperty
	a_off: assert property (p_off) else $error("Off time applied outside boost mode"); // RL9
	property p_sav;
		@(posedge core_clk) disable iff (rst)
		(src_flip && st.power_saving_widths[3:0] != 4'h0) |=> ##1 src_saving_active;
	endproperty
	a_sav: assert property (p_sav) else $error("Source saving not started"); // RL11
endmodule

// File: testbench/epc_host.sv
// Purpose: Host model sending command and parameter bytes to the register bank
// Assumes: One byte per transfer, strobe high for one core_clk cycle
// Notes: Idle lines carry the inverse of the last byte so stale data never matches
`timescale 1ns/1ps
module epc_host (
	input wire logic core_clk,
	output logic byte_valid,
	output logic byte_is_data,
	output logic [7:0] byte_data
);
	// ******************
	// Byte transfers
	// ******************
	initial begin
		byte_valid = 1'b0;
		byte_is_data = 1'b0;
		byte_data = 8'h00;
	end
	// One byte, then the lines are scrambled
	task automatic put(input logic dc, input logic [7:0] b);
		@(posedge core_clk);
		byte_valid <= 1'b1;
		byte_is_data <= dc;
		byte_data <= b;
		@(posedge core_clk);
		byte_valid <= 1'b0;
		byte_is_data <= ~dc;
		byte_data <= ~b;
	endtask
	// Command byte followed by n parameter bytes, at most two
	task automatic cmd(input logic [7:0] c, input int n, input logic [7:0] p1,
		input logic [7:0] p2);
		put(1'b0, c);
		if (n > 0) begin
			put(1'b1, p1);
		end
		if (n > 1) begin
			put(1'b1, p2);
		end
	endtask
endmodule

// File: testbench/epd_power_temp_config_regs_tb.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Host model drives bytes; bench drives sensor, mode and flip inputs
// Notes: Outputs are packed into one word and compared against a queued model word
`timescale 1ns/1ps
module epd_power_temp_config_regs_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic byte_valid, byte_is_data;
	logic [7:0] byte_data;
	logic [7:0] sensor_temp = 8'h00;
	logic boost_switch_mode = 1'b0;
	logic com_flip = 1'b0;
	logic src_flip = 1'b0;
	logic [3:0] source_saving_width, com_saving_width;
	logic [1:0] low_voltage_threshold;
	logic [11:0] lvd_threshold_mv;
	logic temp_source_select, temp_reserved, com_saving_active, src_saving_active;
	logic [7:0] manual_temp_value, active_temp;
	logic [5:0] gate_boost_drive_strength, gate_boost_min_off_time, gate_boost_off_applied;
	logic [1:0] e_lv = 2'h3;
	logic e_sel = 1'b0;
	logic [7:0] e_man = 8'h00;
	logic [7:0] e_pws = 8'h65;
	logic [5:0] e_drv = 6'h10;
	logic [5:0] e_off = 6'h05;
	int x_src = 0, x_com = 0, c_src = 0, c_com = 0, err_total = 0, comparisons = 0;
	logic [79:0] q [$];
	event sample;
	// ******************
	// Clock, parts
	// ******************
	always #12.5 core_clk = ~core_clk;
	epc_host h (.core_clk(core_clk), .byte_valid(byte_valid), .byte_is_data(byte_is_data),
		.byte_data(byte_data));
	epc_regs u_dut (.core_clk(core_clk), .rst(rst), .byte_valid(byte_valid),
		.byte_is_data(byte_is_data), .byte_data(byte_data), .sensor_temp(sensor_temp),
		.boost_switch_mode(boost_switch_mode), .com_flip(com_flip), .src_flip(src_flip),
		.source_saving_width(source_saving_width), .com_saving_width(com_saving_width),
		.low_voltage_threshold(low_voltage_threshold), .lvd_threshold_mv(lvd_threshold_mv),
		.temp_source_select(temp_source_select), .manual_temp_value(manual_temp_value),
		.active_temp(active_temp), .temp_reserved(temp_reserved),
		.gate_boost_drive_strength(gate_boost_drive_strength),
		.gate_boost_min_off_time(gate_boost_min_off_time),
		.gate_boost_off_applied(gate_boost_off_applied),
		.com_saving_active(com_saving_active), .src_saving_active(src_saving_active));
	// ******************
	// Model and monitor
	// ******************
	function automatic logic [79:0] exp_word();
		logic [7:0] t;
		logic rsv;
		t = e_sel ? e_man : sensor_temp;
		rsv = e_sel && ($signed(e_man) < -25 || $signed(e_man) > 50);
		return {e_lv, 12'(2200 + 100 * e_lv), e_sel, e_man, t, rsv, e_drv, e_off,
			boost_switch_mode ? e_off : 6'h00, e_pws, 7'(x_com), 6'(x_src), 9'h000};
	endfunction
	function automatic logic [79:0] snap();
		return {low_voltage_threshold, lvd_threshold_mv, temp_source_select,
			manual_temp_value, active_temp, temp_reserved, gate_boost_drive_strength,
			gate_boost_min_off_time, gate_boost_off_applied, com_saving_width,
			source_saving_width, 7'(c_com), 6'(c_src), 9'h000};
	endfunction
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Saving pulse lengths counted in cycles
	always @(posedge core_clk) begin
		if (src_saving_active === 1'b1) c_src++;
		if (com_saving_active === 1'b1) c_com++;
	end
	always @(sample) begin
		check(snap(), q.pop_front());
	end
	task automatic expect_now();
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		q.push_back(exp_word());
		->sample;
	endtask
	// Widths kept below interval and gap settings; flips both outputs
	task automatic flip_run(input logic [7:0] power_saving_widths);
		h.cmd(epc_pkg::CMD_POWER_SAVING, 1, power_saving_widths, 8'h00);
		e_pws = power_saving_widths;
		c_src = 0;
		c_com = 0;
		src_flip <= 1'b1;
		com_flip <= 1'b1;
		@(posedge core_clk);
		src_flip <= 1'b0;
		com_flip <= 1'b0;
		x_src = (power_saving_widths[3:0] == 4'h0) ? 0 : 20 * power_saving_widths[3:0];
		x_com = 20 * power_saving_widths[7:4];
		repeat (80) @(posedge core_clk);
		expect_now();
	endtask
	task automatic end_sim();
		if (err_total == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ******************
	// Tests
	// ******************
	initial begin
		logic [7:0] tv [5];
		void'($urandom(32'hfd192bfa));
		sensor_temp <= 8'($urandom_range(0, 60));
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		expect_now();
		for (int c = 0; c < 4; c++) begin
			h.cmd(epc_pkg::CMD_LOW_VOLTAGE, 1, 8'(c), 8'h00);
			e_lv = 2'(c);
			expect_now();
		end
		tv = '{8'he7, 8'h32, 8'he6, 8'h33, 8'($urandom_range(0, 50))};
		for (int s = 0; s < 2; s++) begin
			h.cmd(epc_pkg::CMD_TEMP_INPUT_CFG, 1, 8'(s << epc_pkg::TEMP_SRC_BIT), 8'h00);
			e_sel = s[0];
			foreach (tv[i]) begin
				h.cmd(epc_pkg::CMD_MANUAL_TEMP, 1, tv[i], 8'h00);
				e_man = tv[i];
				expect_now();
			end
		end
		for (int b = 0; b < 2; b++) begin
			boost_switch_mode <= b[0];
			e_drv = 6'($urandom);
			e_off = 6'($urandom);
			h.cmd(epc_pkg::CMD_BOOST_SOFT_START, 2, {2'b00, e_drv}, {2'b00, e_off});
			expect_now();
		end
		// Cut a two-byte sequence short with a new command
		h.cmd(epc_pkg::CMD_BOOST_SOFT_START, 1, 8'h2a, 8'h00);
		h.cmd(epc_pkg::CMD_LOW_VOLTAGE, 2, 8'h01, 8'h02);
		e_drv = 6'h2a;
		e_lv = 2'h1;
		expect_now();
		flip_run(8'h21);
		flip_run(8'h30);
		end_sim();
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge core_clk);
		err_total++;
		end_sim();
	end
endmodule
